// >>> port_mux_cfg.svh
// Bit positions and constants for the Port A/B alternate-function mux.
`ifndef PORT_MUX_CFG_SVH
`define PORT_MUX_CFG_SVH

`define PORT_WIDTH         8
`define PIN_COUNT          16
`define PORT_B_BASE        8
`define PB_SCK_BIT         7
`define PB_MISO_BIT        6
`define PB_MOSI_BIT        5
`define PB_SS_BIT          4
`define PB_CMPA_BIT        3
`define PB_CPOS_BIT        2
`define PB_DIVCLK_BIT      1
`define PB_CNT0_BIT        0
`define SYNC_RESET_VALUE   1'b0

`endif

// >>> port_mux_pkg.sv
// Types shared by the Port A/B alternate-function mux.
package port_mux_pkg;

  typedef enum logic [1:0] {
    SPI_OFF,
    SPI_SLAVE,
    SPI_MASTER
  } spi_role_t;

endpackage : port_mux_pkg

// >>> pad_input_sync.sv
// Three-stage pad synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_cfg.svh"

module pad_input_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pad_in,
  output logic      [WIDTH-1:0] level_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  // -------------------------------------------------------------------
  // Synchroniser chain
  // -------------------------------------------------------------------
  // The first stage feeds only the second; nothing else may look at it.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= {WIDTH{`SYNC_RESET_VALUE}};
      stage2_q <= {WIDTH{`SYNC_RESET_VALUE}};
      stage3_q <= {WIDTH{`SYNC_RESET_VALUE}};
    end else begin
      meta_q   <= pad_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  // -------------------------------------------------------------------
  // Agreement filter
  // -------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= {WIDTH{`SYNC_RESET_VALUE}};
    end else begin
      level_q <= (level_q & (stage2_q ^ stage3_q))
               | (stage3_q & ~(stage2_q ^ stage3_q));
    end
  end

endmodule : pad_input_sync
`default_nettype wire

// >>> pin_override_cell.sv
// Generic override resolution for one port pin.
`timescale 1ns/1ps
`default_nettype none

module pin_override_cell (
  input  wire logic dir_bit,
  input  wire logic out_bit,
  input  wire logic global_pullup_disable,
  input  wire logic sleep_active,
  input  wire logic pullup_override_enable,
  input  wire logic pullup_override_value,
  input  wire logic direction_override_enable,
  input  wire logic direction_override_value,
  input  wire logic value_override_enable,
  input  wire logic value_override_value,
  input  wire logic input_enable_override_enable,
  input  wire logic input_enable_override_value,
  output logic      pullup_en,
  output logic      drive_en,
  output logic      drive_value,
  output logic      input_en
);

  always_comb begin
    if (pullup_override_enable) begin
      pullup_en = pullup_override_value;
    end else begin
      pullup_en = !dir_bit && out_bit && !global_pullup_disable;
    end
    if (direction_override_enable) begin
      drive_en = direction_override_value;
    end else begin
      drive_en = dir_bit;
    end
    if (value_override_enable && drive_en) begin
      drive_value = value_override_value;
    end else begin
      drive_value = out_bit;
    end
    if (input_enable_override_enable) begin
      input_en = input_enable_override_value;
    end else begin
      input_en = !sleep_active;
    end
  end

endmodule : pin_override_cell
`default_nettype wire

// >>> port_a_b_alternate_function_mux.sv
// Alternate-function override mux for general-purpose Ports A and B.
//
// Contract
// - Port A pins feed converter channels 0-7.
// - Port A pins are pin-change sources 0-7.
// - Port A overrides only the digital input enable.
// - SPI slave forces clock pin 7 to input.
// - Forced SPI inputs keep pull-up via output bit.
// - SPI master forces data-in pin 6 to input.
// - SPI slave forces data pin 5 to input.
// - SPI slave forces select pin 4 to input.
// - Slave SPI active only while select is low.
// - Pin 4 carries timer0 compare B when output.
// - Pin 3 carries timer0 compare A when output.
// - Pins 3 and 2 feed comparator inputs directly.
// - Pin 2 feeds external interrupt 2.
// - Pin 1 feeds timer1 external count input.
// - Clock fuse drives divided clock onto pin 1.
// - Divided clock keeps running during reset.
// - Port B pins 7-0 are pin-change sources 15-8.
// - Default pull-up needs direction 0, output 1, enable.
// - Driver follows override value or direction bit.
// - Input enable follows override or sleep state.
// - Value override replaces output bit when driving.
`timescale 1ns/1ps
`default_nettype none
`include "port_mux_cfg.svh"

module port_a_b_alternate_function_mux (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Port core register bits and global controls.
  input  wire logic [7:0]             port_a_direction_bit,
  input  wire logic [7:0]             port_a_output_bit,
  input  wire logic [7:0]             port_b_direction_bit,
  input  wire logic [7:0]             port_b_output_bit,
  input  wire logic                   global_pullup_disable,
  input  wire logic                   sleep_active,
  // Pin-change interrupt controls.
  input  wire logic [15:0]            pin_change_source,
  input  wire logic                   pin_change_group0_enable,
  input  wire logic                   pin_change_group1_enable,
  input  wire logic [7:0]             converter_digital_input_disable,
  // SPI controls and outputs.
  input  wire logic                   spi_enable,
  input  wire logic                   spi_master_mode,
  input  wire logic                   spi_clock_out,
  input  wire logic                   spi_slave_data_out,
  input  wire logic                   spi_master_data_out,
  // Timer, interrupt and clock-output controls.
  input  wire logic                   timer0_compare_a_enable,
  input  wire logic                   timer0_compare_a_output,
  input  wire logic                   timer0_compare_b_enable,
  input  wire logic                   timer0_compare_b_output,
  input  wire logic                   external_interrupt2_enable,
  input  wire logic                   clock_output_fuse,
  input  wire logic                   divided_system_clock,
  // Pads.
  input  wire logic [7:0]             port_a_pad_in,
  input  wire logic [7:0]             port_b_pad_in,
  input  wire logic [7:0]             port_a_analog_pad,
  input  wire logic [7:0]             port_b_analog_pad,
  output wire logic [7:0]             port_a_pullup_en,
  output wire logic [7:0]             port_a_drive_en,
  output wire logic [7:0]             port_a_drive_value,
  output wire logic [7:0]             port_b_pullup_en,
  output wire logic [7:0]             port_b_drive_en,
  output wire logic [7:0]             port_b_drive_value,
  // Digital and analog inputs delivered to peripherals.
  output logic      [15:0]            pin_change_level,
  output logic      [7:0]             converter_channel,
  output logic                        comparator_negative_input,
  output logic                        comparator_positive_input,
  output logic                        external_interrupt2_input,
  output logic                        timer1_count_input,
  output logic                        timer0_count_input,
  output logic                        spi_clock_in,
  output logic                        spi_master_data_in,
  output logic                        spi_slave_data_in,
  output logic                        spi_slave_select_n,
  output logic                        spi_slave_selected
);

  import port_mux_pkg::*;

  // -------------------------------------------------------------------
  // Per-pin override vectors, Port A in bits 7:0, Port B in 15:8
  // -------------------------------------------------------------------
  logic [15:0] pullup_override_enable;
  logic [15:0] pullup_override_value;
  logic [15:0] direction_override_enable;
  logic [15:0] direction_override_value;
  logic [15:0] value_override_enable;
  logic [15:0] value_override_value;
  logic [15:0] input_enable_override_enable;
  logic [15:0] input_enable_override_value;
  logic [15:0] all_direction;
  logic [15:0] all_output;
  logic [15:0] all_pullup_en;
  logic [15:0] all_drive_en;
  logic [15:0] all_drive_value;
  logic [15:0] all_input_en;
  logic [15:0] synced_level;
  logic [15:0] digital_in;
  logic [7:0]  port_a_change_armed;
  logic [7:0]  port_b_change_armed;
  spi_role_t   spi_role;

  assign all_direction = {port_b_direction_bit, port_a_direction_bit};
  assign all_output    = {port_b_output_bit, port_a_output_bit};

  // -------------------------------------------------------------------
  // SPI role
  // -------------------------------------------------------------------
  always_comb begin
    if (!spi_enable) begin
      spi_role = SPI_OFF;
    end else if (spi_master_mode) begin
      spi_role = SPI_MASTER;
    end else begin
      spi_role = SPI_SLAVE;
    end
  end

  // -------------------------------------------------------------------
  // Port A overrides
  // -------------------------------------------------------------------
  assign port_a_change_armed = pin_change_source[7:0]
                             & {8{pin_change_group0_enable}};

  // -------------------------------------------------------------------
  // Port B overrides
  // -------------------------------------------------------------------
  assign port_b_change_armed = pin_change_source[15:8]
                             & {8{pin_change_group1_enable}};

  always_comb begin
    pullup_override_enable    = 16'h0000;
    pullup_override_value     = 16'h0000;
    direction_override_enable = 16'h0000;
    direction_override_value  = 16'h0000;
    value_override_enable     = 16'h0000;
    value_override_value      = 16'h0000;
    input_enable_override_enable[7:0]  = port_a_change_armed
                                       | converter_digital_input_disable;
    input_enable_override_value[7:0]   = port_a_change_armed;
    input_enable_override_enable[15:8] = port_b_change_armed;
    input_enable_override_enable[10]   = port_b_change_armed[2]
                                       | external_interrupt2_enable;
    input_enable_override_value[15:8]  = 8'hFF;
    if (spi_role == SPI_SLAVE) begin
      direction_override_enable[15] = 1'b1;
      pullup_override_enable[15]    = 1'b1;
      pullup_override_value[15]     = port_b_output_bit[`PB_SCK_BIT]
                                    & !global_pullup_disable;
    end
    if (spi_role == SPI_MASTER) begin
      value_override_enable[15] = 1'b1;
      value_override_value[15]  = spi_clock_out;
    end
    if (spi_role == SPI_MASTER) begin
      direction_override_enable[14] = 1'b1;
      pullup_override_enable[14]    = 1'b1;
      pullup_override_value[14]     = port_b_output_bit[`PB_MISO_BIT]
                                    & !global_pullup_disable;
    end
    if (spi_role == SPI_SLAVE) begin
      value_override_enable[14] = 1'b1;
      value_override_value[14]  = spi_slave_data_out;
    end
    if (spi_role == SPI_SLAVE) begin
      direction_override_enable[13] = 1'b1;
      pullup_override_enable[13]    = 1'b1;
      pullup_override_value[13]     = port_b_output_bit[`PB_MOSI_BIT]
                                    & !global_pullup_disable;
    end
    if (spi_role == SPI_MASTER) begin
      value_override_enable[13] = 1'b1;
      value_override_value[13]  = spi_master_data_out;
    end
    if (spi_role == SPI_SLAVE) begin
      direction_override_enable[12] = 1'b1;
      pullup_override_enable[12]    = 1'b1;
      pullup_override_value[12]     = port_b_output_bit[`PB_SS_BIT]
                                    & !global_pullup_disable;
    end
    value_override_enable[12] = timer0_compare_b_enable;
    value_override_value[12]  = timer0_compare_b_output;
    value_override_enable[11] = timer0_compare_a_enable;
    value_override_value[11]  = timer0_compare_a_output;
    if (clock_output_fuse) begin
      direction_override_enable[9] = 1'b1;
      direction_override_value[9]  = 1'b1;
      value_override_enable[9]     = 1'b1;
      value_override_value[9]      = divided_system_clock;
    end
  end

  // -------------------------------------------------------------------
  // Per-pin resolution
  // -------------------------------------------------------------------
  // Purely combinational so an override lands in the same cycle; the
  // divided clock therefore also passes straight through during reset.
  genvar p;
  for (p = 0; p < `PIN_COUNT; p++) begin : g_pin
    pin_override_cell u_cell (
      .dir_bit                      (all_direction[p]),
      .out_bit                      (all_output[p]),
      .global_pullup_disable        (global_pullup_disable),
      .sleep_active                 (sleep_active),
      .pullup_override_enable       (pullup_override_enable[p]),
      .pullup_override_value        (pullup_override_value[p]),
      .direction_override_enable    (direction_override_enable[p]),
      .direction_override_value     (direction_override_value[p]),
      .value_override_enable        (value_override_enable[p]),
      .value_override_value         (value_override_value[p]),
      .input_enable_override_enable (input_enable_override_enable[p]),
      .input_enable_override_value  (input_enable_override_value[p]),
      .pullup_en                    (all_pullup_en[p]),
      .drive_en                     (all_drive_en[p]),
      .drive_value                  (all_drive_value[p]),
      .input_en                     (all_input_en[p])
    );
  end

  assign port_a_pullup_en   = all_pullup_en[7:0];
  assign port_a_drive_en    = all_drive_en[7:0];
  assign port_a_drive_value = all_drive_value[7:0];
  assign port_b_pullup_en   = all_pullup_en[15:8];
  assign port_b_drive_en    = all_drive_en[15:8];
  assign port_b_drive_value = all_drive_value[15:8];

  // -------------------------------------------------------------------
  // Digital input path
  // -------------------------------------------------------------------
  pad_input_sync #(
    .WIDTH (`PIN_COUNT)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pad_in   ({port_b_pad_in, port_a_pad_in}),
    .level_q  (synced_level)
  );

  assign digital_in = synced_level & all_input_en;

  always_comb begin
    pin_change_level           = digital_in;
    external_interrupt2_input  = digital_in[`PORT_B_BASE + `PB_CPOS_BIT];
    timer1_count_input         = digital_in[`PORT_B_BASE + `PB_DIVCLK_BIT];
    timer0_count_input         = digital_in[`PORT_B_BASE + `PB_CNT0_BIT];
    spi_clock_in               = digital_in[`PORT_B_BASE + `PB_SCK_BIT];
    spi_master_data_in         = digital_in[`PORT_B_BASE + `PB_MISO_BIT];
    spi_slave_data_in          = digital_in[`PORT_B_BASE + `PB_MOSI_BIT];
    spi_slave_select_n         = digital_in[`PORT_B_BASE + `PB_SS_BIT];
    spi_slave_selected         = (spi_role == SPI_SLAVE)
                               && !spi_slave_select_n;
  end

  // -------------------------------------------------------------------
  // Analog paths
  // -------------------------------------------------------------------
  always_comb begin
    converter_channel         = port_a_analog_pad;
    comparator_negative_input = port_b_analog_pad[`PB_CMPA_BIT];
    comparator_positive_input = port_b_analog_pad[`PB_CPOS_BIT];
  end

endmodule : port_a_b_alternate_function_mux
`default_nettype wire

// >>> periph_model.sv
// Behavioural stand-in for the timer, SPI and clock-divider blocks.
`timescale 1ns/1ps
`default_nettype none

module periph_model (
  input  wire logic core_clk,
  output logic      divided_system_clock,
  output logic      spi_clock_out,
  output logic      spi_slave_data_out,
  output logic      spi_master_data_out,
  output logic      timer0_compare_a_output,
  output logic      timer0_compare_b_output
);
  // --------------------------------------------------------------
  // Free-running sources
  // --------------------------------------------------------------
  // The counter has no reset on purpose: the divided clock must keep
  // toggling while the device is held in reset.
  logic [3:0] cnt_q = 4'h0;

  always_ff @(posedge core_clk) begin
    cnt_q <= cnt_q + 4'h1;
  end

  // Every source changes often, so a stale override shows quickly.
  assign divided_system_clock    = cnt_q[0];
  assign spi_clock_out           = cnt_q[1];
  assign spi_slave_data_out      = cnt_q[2];
  assign spi_master_data_out     = cnt_q[3];
  assign timer0_compare_a_output = cnt_q[1] ^ cnt_q[3];
  assign timer0_compare_b_output = cnt_q[0] ^ cnt_q[2];
endmodule : periph_model
`default_nettype wire

// >>> port_a_b_alternate_function_mux_properties.sv
// Concurrent checks on the ports of the Port A/B override mux.
`timescale 1ns/1ps
`default_nettype none

module mux_checker (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic [7:0]  port_a_direction_bit,
  input wire logic [7:0]  port_a_output_bit,
  input wire logic [7:0]  port_b_direction_bit,
  input wire logic [7:0]  port_b_output_bit,
  input wire logic        global_pullup_disable,
  input wire logic        sleep_active,
  input wire logic [15:0] pin_change_source,
  input wire logic        pin_change_group0_enable,
  input wire logic        spi_enable,
  input wire logic        spi_master_mode,
  input wire logic        timer0_compare_a_enable,
  input wire logic        timer0_compare_a_output,
  input wire logic        timer0_compare_b_enable,
  input wire logic        timer0_compare_b_output,
  input wire logic        clock_output_fuse,
  input wire logic        divided_system_clock,
  input wire logic [7:0]  port_a_pad_in,
  input wire logic [7:0]  port_b_pad_in,
  input wire logic [7:0]  port_a_analog_pad,
  input wire logic [7:0]  port_a_pullup_en,
  input wire logic [7:0]  port_a_drive_en,
  input wire logic [7:0]  port_a_drive_value,
  input wire logic [7:0]  port_b_pullup_en,
  input wire logic [7:0]  port_b_drive_en,
  input wire logic [7:0]  port_b_drive_value,
  input wire logic [15:0] pin_change_level,
  input wire logic [7:0]  converter_channel,
  input wire logic        spi_slave_selected
);
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic slave_on;
  assign slave_on = spi_enable & ~spi_master_mode;

  // Six quiet samples leave room for the four-edge synchroniser.
  sequence s_a0_quiet;
    (pin_change_source[0] && pin_change_group0_enable
     && $stable(port_a_pad_in[0])) [*6];
  endsequence
  sequence s_ss_low;
    (slave_on && !sleep_active && !port_b_pad_in[4]) [*6];
  endsequence

  property p_slave_in;
    slave_on |-> (port_b_drive_en[7:4] & 4'hB) == 4'h0;
  endproperty
  property p_miso_in;
    spi_enable && spi_master_mode |-> !port_b_drive_en[6];
  endproperty
  property p_forced_pull;
    slave_on |->
      port_b_pullup_en[7] == (port_b_output_bit[7] && !global_pullup_disable);
  endproperty
  property p_clk_out;
    clock_output_fuse |->
      port_b_drive_en[1] && port_b_drive_value[1] == divided_system_clock;
  endproperty
  // Reset must not mask this one, so the default disable is overridden.
  property p_clk_out_rst;
    disable iff (1'h0) !rst_n && clock_output_fuse |->
      port_b_drive_en[1] && port_b_drive_value[1] == divided_system_clock;
  endproperty
  property p_a_plain;
    port_a_drive_en == port_a_direction_bit
      && port_a_drive_value == port_a_output_bit;
  endproperty
  property p_a_pull;
    port_a_pullup_en == (~port_a_direction_bit & port_a_output_bit
                         & {8{!global_pullup_disable}});
  endproperty
  property p_cmp_a;
    timer0_compare_a_enable && port_b_direction_bit[3] |->
      port_b_drive_value[3] == timer0_compare_a_output;
  endproperty
  property p_cmp_b;
    timer0_compare_b_enable && port_b_direction_bit[4] && !slave_on |->
      port_b_drive_value[4] == timer0_compare_b_output;
  endproperty
  property p_adc;
    converter_channel == port_a_analog_pad;
  endproperty
  property p_a0_level;
    s_a0_quiet |-> pin_change_level[0] == port_a_pad_in[0];
  endproperty
  property p_ss;
    s_ss_low |-> spi_slave_selected;
  endproperty

  a_slave_in: assert property (p_slave_in)
    else $error("SPI slave input pin still driven");
  a_miso_in: assert property (p_miso_in)
    else $error("SPI master data-in pin still driven");
  a_forced_pull: assert property (p_forced_pull)
    else $error("Forced input pull-up wrong");
  a_clk_out: assert property (p_clk_out)
    else $error("Divided clock not on pin B1");
  a_clk_out_rst: assert property (p_clk_out_rst)
    else $error("Divided clock lost during reset");
  a_a_plain: assert property (p_a_plain)
    else $error("Port A driver overridden");
  a_a_pull: assert property (p_a_pull)
    else $error("Port A pull-up wrong");
  a_cmp_a: assert property (p_cmp_a)
    else $error("Compare A output missing on pin B3");
  a_cmp_b: assert property (p_cmp_b)
    else $error("Compare B output missing on pin B4");
  a_adc: assert property (p_adc)
    else $error("Converter channel not tied to pad");
  a_a0_level: assert property (p_a0_level)
    else $error("Pin-change level 0 does not follow pad");
  a_ss: assert property (p_ss)
    else $error("Slave not selected while select low");
endmodule : mux_checker

bind port_a_b_alternate_function_mux mux_checker i_chk (.*);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the Port A/B alternate-function mux.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        core_clk, rst_n, global_pullup_disable, sleep_active;
  logic        pin_change_group0_enable, pin_change_group1_enable;
  logic        spi_enable, spi_master_mode, timer0_compare_a_enable;
  logic        timer0_compare_b_enable, external_interrupt2_enable;
  logic        clock_output_fuse, divided_system_clock, spi_clock_out;
  logic        spi_slave_data_out, spi_master_data_out;
  logic        timer0_compare_a_output, timer0_compare_b_output;
  logic        comparator_negative_input, comparator_positive_input;
  logic        external_interrupt2_input, timer1_count_input;
  logic        timer0_count_input, spi_clock_in, spi_master_data_in;
  logic        spi_slave_data_in, spi_slave_select_n, spi_slave_selected;
  logic [7:0]  port_a_direction_bit, port_a_output_bit, pm;
  logic [7:0]  port_b_direction_bit, port_b_output_bit;
  logic [7:0]  converter_digital_input_disable, port_a_pad_in;
  logic [7:0]  port_b_pad_in, port_a_analog_pad, port_b_analog_pad;
  logic [7:0]  port_a_pullup_en, port_a_drive_en, port_a_drive_value;
  logic [7:0]  port_b_pullup_en, port_b_drive_en, port_b_drive_value;
  logic [7:0]  converter_channel;
  logic [15:0] pin_change_source, pin_change_level, lfsr;
  logic [23:0] g, e;
  int          fail_count, compares;

  port_a_b_alternate_function_mux i_dut (.*);
  periph_model i_periph (.*);

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], 1'h0} ^ (lfsr[15] ? 16'h6801 : 16'h0000);
    return lfsr;
  endfunction : rnd

  function automatic logic [23:0] exp_b();
    logic [7:0] fi, de, dv;
    logic       slv, mst;
    slv = spi_enable & ~spi_master_mode;
    mst = spi_enable & spi_master_mode;
    fi = {slv, mst, slv, slv, 4'h0};
    de = port_b_direction_bit & ~fi;
    dv = port_b_output_bit;
    if (mst) dv[7] = spi_clock_out;
    if (slv) dv[6] = spi_slave_data_out;
    if (mst) dv[5] = spi_master_data_out;
    if (timer0_compare_b_enable) dv[4] = timer0_compare_b_output;
    if (timer0_compare_a_enable) dv[3] = timer0_compare_a_output;
    if (clock_output_fuse) begin
      de[1] = 1'h1;
      dv[1] = divided_system_clock;
    end
    dv = (dv & de) | (port_b_output_bit & ~de);
    return {(~port_b_direction_bit | fi) & port_b_output_bit & ~pm
            & {8{!global_pullup_disable}}, de, dv};
  endfunction : exp_b

  function automatic logic [23:0] exp_in();
    logic [7:0] ea, eb, a, b;
    ea = (pin_change_source[7:0] & {8{pin_change_group0_enable}})
         | (~converter_digital_input_disable & {8{!sleep_active}});
    eb = (pin_change_source[15:8] & {8{pin_change_group1_enable}})
         | {8{!sleep_active}};
    eb[2] = eb[2] | external_interrupt2_enable;
    a = port_a_pad_in & ea;
    b = port_b_pad_in & eb;
    return {b, a, b[2], b[1], b[0], b[7], b[6], b[5], b[4],
            spi_enable & ~spi_master_mode & ~b[4]};
  endfunction : exp_in

  task automatic check(input logic [23:0] got, input logic [23:0] want);
    compares++;
    if (got !== want) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, want);
    end
  endtask : check

  task automatic scramble();
    {port_a_direction_bit, port_a_output_bit} = rnd();
    {port_b_direction_bit, port_b_output_bit} = rnd();
    pin_change_source = rnd();
    {converter_digital_input_disable, port_a_analog_pad} = rnd();
    {port_b_analog_pad, global_pullup_disable, sleep_active,
     pin_change_group0_enable, pin_change_group1_enable, spi_enable,
     spi_master_mode, timer0_compare_a_enable,
     timer0_compare_b_enable} = rnd();
    // The pads also play the external master pulling select low.
    {port_a_pad_in, port_b_pad_in} = rnd();
    {external_interrupt2_enable, clock_output_fuse} = 2'(rnd());
  endtask : scramble

  task automatic pads();
    // Pull-up on a fuse-driven pin is left open, so it is masked.
    pm = {6'h00, clock_output_fuse, 1'h0};
    e = exp_b();
    check(24'(port_b_pullup_en & ~pm), 24'(e[23:16]));
    check(24'(port_b_drive_en), 24'(e[15:8]));
    check(24'(port_b_drive_value), 24'(e[7:0]));
    e = {port_a_output_bit & ~port_a_direction_bit
         & {8{!global_pullup_disable}}, port_a_direction_bit,
         port_a_output_bit};
    check({port_a_pullup_en, port_a_drive_en, port_a_drive_value}, e);
    g = 24'({converter_channel, comparator_negative_input,
             comparator_positive_input});
    check(g, 24'({port_a_analog_pad, port_b_analog_pad[3:2]}));
  endtask : pads

  task automatic give_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  // --------------------------------------------------------------
  // Clock, watchdog and main sequence
  // --------------------------------------------------------------
  initial begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial begin
    int cyc;
    cyc = 0;
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 2000) begin
        fail_count++;
        give_verdict();
      end
    end
  end

  initial begin
    lfsr = 16'hDFF7;
    fail_count = 0;
    compares = 0;
    rst_n = 1'h0;
    scramble();
    repeat (8) @(posedge core_clk);
    #2;
    rst_n = 1'h1;
    for (int i = 0; i < 400; i++) begin
      @(posedge core_clk);
      #2;
      scramble();
      if (i < 4) begin
        spi_enable = 1'h1;
        spi_master_mode = i[0];
        port_b_direction_bit = 8'hFF;
        port_b_output_bit = {8{i[1]}};
      end
      #10;
      pads();
    end
    for (int i = 0; i < 60; i++) begin
      @(posedge core_clk);
      #2;
      scramble();
      repeat (6) @(posedge core_clk);
      #2;
      g = {pin_change_level, external_interrupt2_input, timer1_count_input,
           timer0_count_input, spi_clock_in, spi_master_data_in,
           spi_slave_data_in, spi_slave_select_n, spi_slave_selected};
      check(g, exp_in());
    end
    @(posedge core_clk);
    #2;
    clock_output_fuse = 1'h1;
    port_b_direction_bit = 8'h00;
    rst_n = 1'h0;
    repeat (3) begin
      @(posedge core_clk);
      #10;
      check(24'({port_b_drive_en[1], port_b_drive_value[1]}),
            24'({1'h1, divided_system_clock}));
    end
    @(posedge core_clk);
    #2;
    rst_n = 1'h1;
    repeat (8) @(posedge core_clk);
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
